// ### ctc_classifier.sv
// Functional notes
// - conditional branches are direct, never checked
// - jal reaches plus/minus one mebibyte, direct
// - jalr target is rs1 plus simm12
// - jal/jalr with rd not x0 is call
// - jal/c.jal direct call; jalr/c.jalr indirect
// - jalr rd x0, rs1 x1/x5 is return
// - jalr rd x0, other rs1 is jump
// - c.jalr links pc+2 into x1, call
// - c.jr returns via x1/x5, else jumps
// - c.j and c.jal direct, no check
// - c.jr and c.jalr go to rs1
// - call/return hints feed return prediction only
`timescale 1ns/1ns
`default_nettype none
`include "ctc_params.svh"

module ctc_classifier #(
  parameter int XLEN = 32,
  parameter bit HAS_CJAL = 1'b1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic in_valid,
  input wire logic [31:0] in_instr,
  input wire logic [XLEN-1:0] in_pc,
  input wire logic [XLEN-1:0] in_rs1_val,
  output logic out_valid,
  output ctc_pkg::ctc_kind_t out_kind,
  output logic out_direct_jump,
  output logic out_direct_call,
  output logic out_indirect_call,
  output logic out_return,
  output logic out_indirect_jump,
  output logic out_cond_branch,
  output logic out_check_req,
  output logic out_ras_push,
  output logic out_ras_pop,
  output logic [XLEN-1:0] out_target,
  output logic [XLEN-1:0] out_link,
  output logic [4:0] out_link_rd,
  output logic out_link_we
);

  // 32-bit instruction fields
  logic [6:0] op;
  logic [4:0] rd;
  logic [2:0] f3;
  logic [4:0] rs1;
  logic wide;
  // compressed fields
  logic [4:0] c_rs1;
  logic [4:0] c_rs2;
  logic [2:0] c_f3;
  logic [3:0] c_f4;
  // decoded forms, at most one true at a time
  logic dec_jal;
  logic dec_jalr;
  logic dec_br;
  logic dec_cj;
  logic dec_cjal;
  logic dec_cjr;
  logic dec_cjalr;
  // sign-extended offsets
  logic [XLEN-1:0] jal_ext;
  logic [XLEN-1:0] jalr_ext;
  logic [XLEN-1:0] br_ext;
  logic [XLEN-1:0] cj_ext;
  logic [20:0] jal_imm;
  logic [12:0] br_imm;
  logic [11:0] cj_imm;

  // registered outputs and their next values
  logic valid_reg;
  logic valid_next;
  ctc_pkg::ctc_kind_t kind_reg;
  ctc_pkg::ctc_kind_t kind_next;
  logic br_reg;
  logic br_next;
  logic [XLEN-1:0] target_reg;
  logic [XLEN-1:0] target_next;
  logic [XLEN-1:0] link_reg;
  logic [XLEN-1:0] link_next;
  logic [4:0] rd_reg;
  logic [4:0] rd_next;
  logic we_reg;
  logic we_next;

  // true for the two conventional link registers
  function automatic logic is_link(input logic [4:0] r);
    is_link = (r == `CTC_REG_RA) || (r == `CTC_REG_ALT);
  endfunction : is_link

  // field extraction
  assign op = in_instr[6:0];
  assign rd = in_instr[11:7];
  assign f3 = in_instr[14:12];
  assign rs1 = in_instr[19:15];
  assign wide = (in_instr[1:0] == `CTC_Q_WIDE);
  assign c_rs1 = in_instr[11:7];
  assign c_rs2 = in_instr[6:2];
  assign c_f3 = in_instr[15:13];
  assign c_f4 = in_instr[15:12];

  // form decode; compressed forms only look at the low half
  assign dec_jal = wide && (op == `CTC_OP_JAL);
  assign dec_jalr = wide && (op == `CTC_OP_JALR) && (f3 == `CTC_F3_JALR);
  assign dec_br = wide && (op == `CTC_OP_BRANCH)
    && (f3 != `CTC_F3_BR_BAD0) && (f3 != `CTC_F3_BR_BAD1);
  assign dec_cj = (in_instr[1:0] == `CTC_Q_ONE) && (c_f3 == `CTC_CF3_CJ);
  // the linking offset jump only where HAS_CJAL says the core has it
  assign dec_cjal = HAS_CJAL && (in_instr[1:0] == `CTC_Q_ONE)
    && (c_f3 == `CTC_CF3_CJAL);
  // rs1 of x0 is reserved (or a breakpoint), so it is no transfer
  assign dec_cjr = (in_instr[1:0] == `CTC_Q_TWO) && (c_f4 == `CTC_CF4_CJR)
    && (c_rs2 == `CTC_REG_ZERO) && (c_rs1 != `CTC_REG_ZERO);
  assign dec_cjalr = (in_instr[1:0] == `CTC_Q_TWO) && (c_f4 == `CTC_CF4_CJALR)
    && (c_rs2 == `CTC_REG_ZERO) && (c_rs1 != `CTC_REG_ZERO);

  assign jal_imm = {in_instr[31], in_instr[19:12], in_instr[20], in_instr[30:21], 1'b0};
  assign jal_ext = {{(XLEN-21){jal_imm[20]}}, jal_imm};
  assign jalr_ext = {{(XLEN-12){in_instr[31]}}, in_instr[31:20]};
  assign br_imm = {in_instr[31], in_instr[7], in_instr[30:25], in_instr[11:8], 1'b0};
  assign br_ext = {{(XLEN-13){br_imm[12]}}, br_imm};
  assign cj_imm = {in_instr[12], in_instr[8], in_instr[10:9], in_instr[6], in_instr[7],
    in_instr[2], in_instr[11], in_instr[5:3], 1'b0};
  assign cj_ext = {{(XLEN-12){cj_imm[11]}}, cj_imm};

  // next classification, target and link for one instruction
  always_comb begin
    valid_next = in_valid;
    kind_next = ctc_pkg::CTC_NONE;
    br_next = 1'b0;
    target_next = '0;
    link_next = '0;
    rd_next = `CTC_REG_ZERO;
    we_next = 1'b0;
    if (in_valid) begin
      if (dec_jal) begin
        target_next = in_pc + jal_ext;
        link_next = in_pc + XLEN'(`CTC_STEP_WIDE);
        rd_next = rd;
        we_next = (rd != `CTC_REG_ZERO);
        kind_next = (rd != `CTC_REG_ZERO) ? ctc_pkg::CTC_DCALL : ctc_pkg::CTC_DJUMP;
      end else if (dec_jalr) begin
        target_next = in_rs1_val + jalr_ext;
        link_next = in_pc + XLEN'(`CTC_STEP_WIDE);
        rd_next = rd;
        we_next = (rd != `CTC_REG_ZERO);
        if (rd != `CTC_REG_ZERO) begin
          kind_next = ctc_pkg::CTC_ICALL;
        end else if (is_link(rs1)) begin
          kind_next = ctc_pkg::CTC_RET;
        end else begin
          kind_next = ctc_pkg::CTC_IJUMP;
        end
      end else if (dec_br) begin
        br_next = 1'b1;
        target_next = in_pc + br_ext;
      end else if (dec_cj || dec_cjal) begin
        target_next = in_pc + cj_ext;
        link_next = in_pc + XLEN'(`CTC_STEP_SHORT);
        rd_next = dec_cjal ? `CTC_REG_RA : `CTC_REG_ZERO;
        we_next = dec_cjal;
        kind_next = dec_cjal ? ctc_pkg::CTC_DCALL : ctc_pkg::CTC_DJUMP;
      end else if (dec_cjalr) begin
        target_next = in_rs1_val;
        link_next = in_pc + XLEN'(`CTC_STEP_SHORT);
        rd_next = `CTC_REG_RA;
        we_next = 1'b1;
        kind_next = ctc_pkg::CTC_ICALL;
      end else if (dec_cjr) begin
        target_next = in_rs1_val;
        kind_next = is_link(c_rs1) ? ctc_pkg::CTC_RET : ctc_pkg::CTC_IJUMP;
      end
    end
  end

  // register stage; low enable holds everything
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      valid_reg <= 1'b0;
      kind_reg <= ctc_pkg::ctc_kind_t'(`CTC_KIND_RST);
      br_reg <= 1'b0;
      target_reg <= '0;
      link_reg <= '0;
      rd_reg <= `CTC_REG_ZERO;
      we_reg <= 1'b0;
    end else if (clk_en) begin
      valid_reg <= valid_next;
      kind_reg <= kind_next;
      br_reg <= br_next;
      target_reg <= target_next;
      link_reg <= link_next;
      rd_reg <= rd_next;
      we_reg <= we_next;
    end
  end

  // outputs; class flags are a pure decode of kind_reg and the branch flag is br_reg, so at most one is set
  assign out_valid = valid_reg;
  assign out_kind = kind_reg;
  assign out_direct_jump = (kind_reg == ctc_pkg::CTC_DJUMP);
  assign out_direct_call = (kind_reg == ctc_pkg::CTC_DCALL);
  assign out_indirect_call = (kind_reg == ctc_pkg::CTC_ICALL);
  assign out_return = (kind_reg == ctc_pkg::CTC_RET);
  assign out_indirect_jump = (kind_reg == ctc_pkg::CTC_IJUMP);
  assign out_cond_branch = br_reg;
  // only register-sourced targets go to the integrity checker
  assign out_check_req = out_indirect_call || out_indirect_jump;
  assign out_ras_push = out_direct_call || out_indirect_call;
  assign out_ras_pop = out_return;
  assign out_target = target_reg;
  assign out_link = link_reg;
  assign out_link_rd = rd_reg;
  assign out_link_we = we_reg;

  // assertion helpers
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // accepted instructions of the jal, jalr, c.jalr and c.jr forms
  sequence s_jal;
    clk_en && in_valid && dec_jal;
  endsequence
  sequence s_jalr;
    clk_en && in_valid && dec_jalr;
  endsequence
  sequence s_cjalr;
    clk_en && in_valid && dec_cjalr;
  endsequence
  sequence s_cjr;
    clk_en && in_valid && dec_cjr;
  endsequence

  kind_onehot_a: assert property (
    $onehot0({out_direct_jump, out_direct_call, out_indirect_call, out_return,
      out_indirect_jump, out_cond_branch}))
    else $error("more than one class flagged");

  branch_direct_a: assert property (
    clk_en && in_valid && dec_br |=> out_cond_branch && !out_check_req
      && out_target == $past(in_pc) + $past(br_ext))
    else $error("branch not a direct transfer");

  jal_target_a: assert property (
    s_jal |=> !out_check_req && out_target == $past(in_pc) + $past(jal_ext))
    else $error("jal target wrong");

  jalr_target_a: assert property (
    s_jalr |=> out_target == $past(in_rs1_val) + $past(jalr_ext))
    else $error("jalr target wrong");

  call_class_a: assert property (
    (s_jal or s_jalr) ##0 (rd != `CTC_REG_ZERO) |=> out_ras_push && out_link_we)
    else $error("linking jump not a call");

  ret_class_a: assert property (
    s_jalr ##0 (rd == `CTC_REG_ZERO && is_link(rs1)) |=> out_return && !out_check_req)
    else $error("return not classed");

  ijump_class_a: assert property (
    s_jalr ##0 (rd == `CTC_REG_ZERO && !is_link(rs1)) |=> out_indirect_jump)
    else $error("indirect jump not classed");

  cjalr_link_a: assert property (
    s_cjalr |=> out_indirect_call && out_link_rd == `CTC_REG_RA
      && out_link == $past(in_pc) + XLEN'(`CTC_STEP_SHORT))
    else $error("compressed call link wrong");

  cjr_target_a: assert property (
    (s_cjr or s_cjalr) |=> out_target == $past(in_rs1_val) && !out_link_we == $past(dec_cjr))
    else $error("compressed register jump target wrong");

  cjr_class_a: assert property (
    s_cjr |=> (out_return == $past(is_link(c_rs1))) && (out_indirect_jump != out_return))
    else $error("compressed jr class wrong");

  coff_direct_a: assert property (
    clk_en && in_valid && (dec_cj || dec_cjal) |=> !out_check_req
      && (out_direct_jump || out_direct_call))
    else $error("compressed offset jump not direct");

  hold_state_a: assert property (
    !clk_en |=> $stable(out_target) && $stable(out_kind) && $stable(out_valid))
    else $error("state moved while enable low");

endmodule : ctc_classifier

`default_nettype wire

// ### ctc_params.svh
`ifndef CTC_PARAMS_SVH
`define CTC_PARAMS_SVH

// 32-bit major opcodes of the control transfers
`define CTC_OP_JAL 7'h6f
`define CTC_OP_JALR 7'h67
`define CTC_OP_BRANCH 7'h63
// jalr only exists with this funct3
`define CTC_F3_JALR 3'h0
// branch funct3 codes that are not defined
`define CTC_F3_BR_BAD0 3'h2
`define CTC_F3_BR_BAD1 3'h3
// quadrant field of 32-bit and compressed forms
`define CTC_Q_WIDE 2'h3
`define CTC_Q_ONE 2'h1
`define CTC_Q_TWO 2'h2
// compressed funct3 for the two offset jumps
`define CTC_CF3_CJ 3'h5
`define CTC_CF3_CJAL 3'h1
// compressed top nibble for register jumps
`define CTC_CF4_CJR 4'h8
`define CTC_CF4_CJALR 4'h9
// register numbers
`define CTC_REG_ZERO 5'h00
`define CTC_REG_RA 5'h01
`define CTC_REG_ALT 5'h05
// link offsets: wide and compressed instruction sizes
`define CTC_STEP_WIDE 4
`define CTC_STEP_SHORT 2
// reset value of the classification
`define CTC_KIND_RST 3'h0

`endif

// ### ctc_pkg.sv
`default_nettype none

package ctc_pkg;
  // classification of one instruction; none is the idle code
  typedef enum logic [2:0] {
    CTC_NONE = 3'h0,
    CTC_DJUMP = 3'h1,
    CTC_DCALL = 3'h3,
    CTC_ICALL = 3'h2,
    CTC_RET = 3'h6,
    CTC_IJUMP = 3'h7
  } ctc_kind_t;
endpackage : ctc_pkg

`default_nettype wire

// ### ctc_ras_model.sv
`timescale 1ns/1ns
`default_nettype none

// return-stack depth tracker standing in for the prediction logic
module ctc_ras_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic push,
  input wire logic pop,
  output logic [3:0] depth
);
  logic [3:0] depth_reg; // entries the predictor believes live
  logic [3:0] depth_next;
  // hints move depth
  // no saturation: a wrap shows up as a wrong count, which is what we want
  always_comb begin
    depth_next = depth_reg + {3'h0, push} - {3'h0, pop};
  end
  // frozen with the pipeline so a stalled result is counted once
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      depth_reg <= 4'h0;
    end else if (clk_en) begin
      depth_reg <= depth_next;
    end
  end
  assign depth = depth_reg;
endmodule : ctc_ras_model

`default_nettype wire

// ### test_control_transfer_classifier.sv
`timescale 1ns/1ns
`default_nettype none

module test_control_transfer_classifier;
  localparam logic [31:0] P = 32'h0040_0000; // pc used throughout
  localparam logic [31:0] R = 32'h1234_5679; // odd rs1 shows bit 0 is kept
  logic clock;
  logic nrst;
  logic clk_en;
  logic in_valid;
  logic [31:0] in_instr;
  logic [31:0] in_pc;
  logic [31:0] in_rs1_val;
  logic out_valid;
  ctc_pkg::ctc_kind_t out_kind;
  // class, branch, check, push and pop flags; a net, since nine ports each drive one bit
  wire [8:0] fl;
  logic [31:0] out_target;
  logic [31:0] out_link;
  logic [4:0] out_link_rd;
  logic out_link_we;
  logic [3:0] ras_depth;
  int bad_count;
  int n_tests;

  ctc_classifier ctc_classifier_inst (.clock(clock), .nrst(nrst), .clk_en(clk_en),
    .in_valid(in_valid), .in_instr(in_instr), .in_pc(in_pc), .in_rs1_val(in_rs1_val),
    .out_valid(out_valid), .out_kind(out_kind), .out_direct_jump(fl[8]),
    .out_direct_call(fl[7]), .out_indirect_call(fl[6]), .out_return(fl[5]),
    .out_indirect_jump(fl[4]), .out_cond_branch(fl[3]), .out_check_req(fl[2]),
    .out_ras_push(fl[1]), .out_ras_pop(fl[0]), .out_target(out_target),
    .out_link(out_link), .out_link_rd(out_link_rd), .out_link_we(out_link_we));

  ctc_ras_model ctc_ras_model_inst (.clock(clock), .nrst(nrst), .clk_en(clk_en),
    .push(fl[1]), .pop(fl[0]), .depth(ras_depth));

  // 25 MHz core clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // drive one word at a falling edge, judge every output at the next falling edge
  task automatic run_one(input logic [31:0] instr, input logic [31:0] pc,
      input ctc_pkg::ctc_kind_t k, input logic [31:0] tgt, input logic [31:0] lnk,
      input logic [4:0] rd, input logic br);
    logic dj;
    logic dc;
    logic ic;
    logic rt;
    logic ij;
    dj = k == ctc_pkg::CTC_DJUMP;
    dc = k == ctc_pkg::CTC_DCALL;
    ic = k == ctc_pkg::CTC_ICALL;
    rt = k == ctc_pkg::CTC_RET;
    ij = k == ctc_pkg::CTC_IJUMP;
    in_valid = 1'b1;
    in_instr = instr;
    in_pc = pc;
    in_rs1_val = R;
    @(negedge clock);
    check({28'h0, out_valid, out_kind}, {28'h1, k});
    check({23'h0, fl}, {23'h0, dj, dc, ic, rt, ij, br, ic | ij, dc | ic, rt});
    check(out_target, tgt);
    check(out_link, lnk);
    check({26'h0, out_link_rd, out_link_we}, {26'h0, rd, rd != 5'h0});
  endtask : run_one

  task automatic t_branch;
    run_one(32'h0200_0063, P, ctc_pkg::CTC_NONE, P + 32'h20, 32'h0, 5'h0, 1'b1);
  endtask : t_branch

  task automatic t_jal;
    run_one(32'h0080_02ef, P, ctc_pkg::CTC_DCALL, P + 32'h8, P + 32'h4, 5'h5, 1'b0);
    run_one(32'h8000_006f, P, ctc_pkg::CTC_DJUMP, 32'h0030_0000, P + 32'h4, 5'h0, 1'b0);
    run_one(32'h0080_01ef, P, ctc_pkg::CTC_DCALL, P + 32'h8, P + 32'h4, 5'h3, 1'b0);
  endtask : t_jal

  task automatic t_jalr;
    run_one(32'hffc0_8067, P, ctc_pkg::CTC_RET, R - 32'h4, P + 32'h4, 5'h0, 1'b0);
    run_one(32'hffc2_8067, P, ctc_pkg::CTC_RET, R - 32'h4, P + 32'h4, 5'h0, 1'b0);
    run_one(32'hffc3_0067, P, ctc_pkg::CTC_IJUMP, R - 32'h4, P + 32'h4, 5'h0, 1'b0);
    run_one(32'hffc0_80e7, P, ctc_pkg::CTC_ICALL, R - 32'h4, P + 32'h4, 5'h1, 1'b0);
    run_one(32'h7ff4_8067, P, ctc_pkg::CTC_IJUMP, R + 32'h7ff, P + 32'h4, 5'h0, 1'b0);
  endtask : t_jalr

  // upper half of the first word is junk the decoder must ignore
  task automatic t_comp;
    run_one(32'hdead_9282, P, ctc_pkg::CTC_ICALL, R, P + 32'h2, 5'h1, 1'b0);
    run_one(32'h0000_8082, P, ctc_pkg::CTC_RET, R, 32'h0, 5'h0, 1'b0);
    run_one(32'h0000_8382, P, ctc_pkg::CTC_IJUMP, R, 32'h0, 5'h0, 1'b0);
    // scattered offset bits 10, 6 and 4, then a sign-only offset
    run_one(32'h0000_a981, P, ctc_pkg::CTC_DJUMP, P + 32'h450, P + 32'h2, 5'h0, 1'b0);
    run_one(32'h0000_3001, P, ctc_pkg::CTC_DCALL, P - 32'h800, P + 32'h2, 5'h1, 1'b0);
  endtask : t_comp

  // reserved and ordinary words carry no class at all
  task automatic t_none;
    run_one(32'h0000_8002, P, ctc_pkg::CTC_NONE, 32'h0, 32'h0, 5'h0, 1'b0);
    run_one(32'h0200_2063, P, ctc_pkg::CTC_NONE, 32'h0, 32'h0, 5'h0, 1'b0);
    run_one(32'hffc0_9067, P, ctc_pkg::CTC_NONE, 32'h0, 32'h0, 5'h0, 1'b0);
    run_one(32'h0000_0013, P, ctc_pkg::CTC_NONE, 32'h0, 32'h0, 5'h0, 1'b0);
  endtask : t_none

  // a stalled result must hold, an empty slot must clear
  task automatic t_stall;
    run_one(32'h0080_02ef, P, ctc_pkg::CTC_DCALL, P + 32'h8, P + 32'h4, 5'h5, 1'b0);
    clk_en = 1'b0;
    in_instr = 32'h0000_8382;
    @(negedge clock);
    check({29'h0, out_kind}, {29'h0, ctc_pkg::CTC_DCALL});
    clk_en = 1'b1;
    in_valid = 1'b0;
    @(negedge clock);
    check({23'h0, out_valid, out_kind, out_target[0]}, 32'h0);
  endtask : t_stall

  // six pushes and three pops went by since reset; the stalled call counts once
  task automatic t_ras;
    @(negedge clock);
    check({28'h0, ras_depth}, 32'h3);
  endtask : t_ras

  // asynchronous reset in mid-run clears outputs before any edge
  task automatic t_reset;
    in_valid = 1'b1;
    nrst = 1'b0;
    #5;
    check({23'h0, out_valid, fl}, 32'h0);
    check(out_target | out_link, 32'h0);
    @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    // the first edge after release already takes the waiting register jump through x7
    check({28'h0, out_valid, out_kind}, {28'h1, ctc_pkg::CTC_IJUMP});
    check(out_target, R);
  endtask : t_reset

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    bad_count = 0;
    n_tests = 0;
    nrst = 1'b0;
    clk_en = 1'b1;
    in_valid = 1'b0;
    in_instr = 32'h0;
    in_pc = 32'h0;
    in_rs1_val = 32'h0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    t_branch();
    t_jal();
    t_jalr();
    t_comp();
    t_none();
    t_stall();
    t_ras();
    t_reset();
    print_verdict();
  end
endmodule : test_control_transfer_classifier

`default_nettype wire
